// ### rtl/fcd_pkg.sv
package fcd_pkg;

    // Clock period of ref_clk in nanoseconds.
    localparam int unsigned CLK_NS = 25;

    // Longest gap allowed between two bytes of one instruction, in microseconds.
    localparam int unsigned INTERBYTE_US = 80;
    // Sector erase window, its nominal length and its margin in percent.
    localparam int unsigned ERASE_WIN_US = 100;
    localparam int unsigned ERASE_WIN_PCT = 20;
    // Time that poll and toggle hold at zero after a fully protected erase.
    localparam int unsigned PROT_HOLD_US = 100;

    // Cycle counts; these are longest times, so they round down.
    localparam int unsigned INTERBYTE_CYC = INTERBYTE_US * 1000 / CLK_NS;
    localparam int unsigned ERASE_WIN_CYC =
        ERASE_WIN_US * 1000 * (100 + ERASE_WIN_PCT) / 100 / CLK_NS;
    localparam int unsigned PROT_HOLD_CYC = PROT_HOLD_US * 1000 / CLK_NS;

    // Coded cycle addresses, low twelve bits only.
    localparam logic [11:0] ADDR_CODE1 = 12'hAAA;
    localparam logic [11:0] ADDR_CODE2 = 12'h554;
    // Read offsets inside identifier mode, low eight bits of the address.
    localparam logic [7:0] OFS_IDENT = 8'h02;
    localparam logic [7:0] OFS_PROT = 8'h04;

    // Instruction byte values.
    localparam logic [7:0] CMD_CODE1 = 8'hAA;
    localparam logic [7:0] CMD_CODE2 = 8'h55;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_SECT = 8'h30;
    localparam logic [7:0] CMD_BULK = 8'h10;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    // Answers of the protection-status read.
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;

    // Identifier of the primary array; the value is arbitrary.
    localparam logic [7:0] IDENT_CODE = 8'h5A;

    // Decoder states.
    typedef enum logic [3:0] {
        ST_READ, ST_CYC1, ST_CYC2, ST_PROG, ST_ERS1, ST_ERS2, ST_ERS3,
        ST_ERS_WIN, ST_BUSY, ST_HOLD, ST_FAIL, ST_IDENT, ST_BYP,
        ST_BYP_PROG, ST_BYP_EXIT
    } fcd_state_t;

    // Operations handed to the embedded algorithm.
    typedef enum logic [1:0] {
        OP_NONE, OP_PROG, OP_SECT, OP_BULK
    } fcd_op_t;

    // Status byte layout, bit 7 first.
    typedef struct packed {
        logic poll;
        logic toggle;
        logic failure;
        logic rsv4;
        logic erase_window;
        logic [2:0] rsv2_0;
    } fcd_status_t;

    // Command to the embedded program and erase algorithm.
    typedef struct packed {
        logic start;
        fcd_op_t op;
        logic bank;
        logic [15:0] addr;
        logic [15:0] data;
        logic [7:0] sectors;
    } fcd_alg_cmd_t;

    // Whole state of the decoder.
    typedef struct packed {
        fcd_state_t st;
        logic bank;
        logic bypass;
        logic err;
        logic tog;
        logic [12:0] tmr;
        fcd_alg_cmd_t cmd;
        logic [15:0] rdata;
    } fcd_regs_t;

    // Timer and register values after reset.
    localparam logic [12:0] TMR_RESET = 13'h0000;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

endpackage : fcd_pkg

// ### rtl/fcd_top.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps

module fcd_top #(
    // Length of the sector erase window in ref_clk cycles.
    parameter int unsigned ERASE_WIN_CYCLES = fcd_pkg::ERASE_WIN_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    input wire logic [7:0] primary_sector_selects,
    input wire logic [3:0] secondary_sector_selects,
    input wire logic [15:0] array_rdata,
    input wire logic sector_protected,
    input wire logic all_protected,
    input wire logic alg_busy,
    input wire logic alg_fail,
    output fcd_pkg::fcd_alg_cmd_t alg_cmd
);

    // Registered state and its next value.
    fcd_pkg::fcd_regs_t r_q;
    fcd_pkg::fcd_regs_t r_d;

    // Timer loads, cut to the timer width.
    localparam logic [12:0] TMR_BYTE = 13'(fcd_pkg::INTERBYTE_CYC);
    localparam logic [12:0] TMR_HOLD = 13'(fcd_pkg::PROT_HOLD_CYC);
    logic [12:0] tmr_win;
    assign tmr_win = 13'(ERASE_WIN_CYCLES);

    // Bank select decode and helpers, all combinational.
    logic sel_p;
    logic sel_s;
    logic sel_any;
    logic sel_bank;
    logic hit;
    logic [7:0] sel_mask;
    logic [7:0] wbyte;
    logic code1;
    logic code2;
    logic even;
    logic busy_exit;
    fcd_pkg::fcd_state_t cur;

    // Builds one status byte from the live flags and a poll value.
    function automatic logic [7:0] mk_status(input logic poll, input logic tog,
                                             input logic err, input logic ewin);
        fcd_pkg::fcd_status_t s;
        s = '0;
        s.poll = poll;
        s.toggle = tog;
        s.failure = err;
        s.erase_window = ewin;
        return s;
    endfunction : mk_status

    // Outputs come straight from the state register.
    assign bus_rdata = r_q.rdata;
    assign alg_cmd = r_q.cmd;

    // Next-state logic of the whole decoder.
    always_comb begin
        r_d = r_q;
        // The start pulse and read data last one cycle only.
        r_d.cmd.start = 1'b0;
        r_d.rdata = fcd_pkg::RDATA_RESET;
        sel_p = |primary_sector_selects;
        sel_s = |secondary_sector_selects;
        sel_any = sel_p | sel_s;
        sel_bank = ~sel_p;
        hit = r_q.bank ? sel_s : sel_p;
        sel_mask = sel_p ? primary_sector_selects : {4'h0, secondary_sector_selects};
        wbyte = bus_wdata[7:0];
        code1 = bus_addr[11:0] == fcd_pkg::ADDR_CODE1;
        code2 = bus_addr[11:0] == fcd_pkg::ADDR_CODE2;
        even = ~bus_addr[0];
        busy_exit = ~alg_busy & ~r_q.cmd.start;

        if (r_q.tmr != '0) begin
            r_d.tmr = r_q.tmr - 13'h0001;
        end

        cur = r_q.st;
        if (r_q.tmr == '0) begin
            case (r_q.st)
                fcd_pkg::ST_CYC1, fcd_pkg::ST_CYC2, fcd_pkg::ST_PROG,
                fcd_pkg::ST_ERS1, fcd_pkg::ST_ERS2, fcd_pkg::ST_ERS3: begin
                    cur = fcd_pkg::ST_READ;
                end
                fcd_pkg::ST_BYP_PROG, fcd_pkg::ST_BYP_EXIT: begin
                    cur = fcd_pkg::ST_BYP;
                end
                fcd_pkg::ST_HOLD: begin
                    cur = fcd_pkg::ST_READ;
                end
                fcd_pkg::ST_ERS_WIN: begin
                    if (r_q.cmd.sectors != '0) begin
                        r_d.cmd.start = 1'b1;
                        r_d.cmd.op = fcd_pkg::OP_SECT;
                        cur = fcd_pkg::ST_BUSY;
                    end else begin
                        r_d.tmr = TMR_HOLD;
                        cur = fcd_pkg::ST_HOLD;
                    end
                end
                default: begin
                    cur = r_q.st;
                end
            endcase
        end

        // The algorithm finishing ends the busy state; a failure with the last busy cycle counts.
        if (r_q.st == fcd_pkg::ST_BUSY && busy_exit) begin
            if (r_q.err || alg_fail) begin
                cur = fcd_pkg::ST_FAIL;
            end else if (r_q.bypass) begin
                cur = fcd_pkg::ST_BYP;
            end else begin
                cur = fcd_pkg::ST_READ;
            end
        end
        r_d.st = cur;

        // Read answers, one cycle after the strobe.
        if (bus_rd) begin
            r_d.rdata = array_rdata;
            case (cur)
                fcd_pkg::ST_IDENT: begin
                    if (bus_addr[7:0] == fcd_pkg::OFS_IDENT && !r_q.bank) begin
                        r_d.rdata = {8'h00, fcd_pkg::IDENT_CODE};
                    end else if (bus_addr[7:0] == fcd_pkg::OFS_PROT) begin
                        r_d.rdata = {8'h00, sector_protected ? fcd_pkg::PROT_YES
                                                             : fcd_pkg::PROT_NO};
                    end
                end
                fcd_pkg::ST_ERS_WIN, fcd_pkg::ST_BUSY, fcd_pkg::ST_FAIL: begin
                    if (hit) begin
                        r_d.tog = ~r_q.tog;
                        if (r_q.cmd.op == fcd_pkg::OP_PROG) begin
                            r_d.rdata = {mk_status(~r_q.cmd.data[15], r_q.tog, r_q.err, 1'b0),
                                         mk_status(~r_q.cmd.data[7], r_q.tog, r_q.err, 1'b0)};
                        end else begin
                            r_d.rdata = {2{mk_status(1'b0, r_q.tog, r_q.err,
                                                     cur != fcd_pkg::ST_ERS_WIN)}};
                        end
                    end
                end
                fcd_pkg::ST_HOLD: begin
                    if (hit) begin
                        r_d.rdata = {2{mk_status(1'b0, 1'b0, r_q.err, 1'b1)}};
                    end
                end
                default: begin
                    r_d.rdata = array_rdata;
                end
            endcase
        end

        if (bus_wr && (cur == fcd_pkg::ST_READ ? sel_any : hit)) begin
            case (cur)
                fcd_pkg::ST_READ: begin
                    if (wbyte == fcd_pkg::CMD_CODE1 && code1) begin
                        r_d.st = fcd_pkg::ST_CYC1;
                        r_d.bank = sel_bank;
                        r_d.tmr = TMR_BYTE;
                    end else if (wbyte == fcd_pkg::CMD_RESET && even) begin
                        r_d.err = 1'b0;
                    end
                end
                fcd_pkg::ST_CYC1: begin
                    r_d.st = fcd_pkg::ST_READ;
                    if (wbyte == fcd_pkg::CMD_CODE2 && code2) begin
                        r_d.st = fcd_pkg::ST_CYC2;
                        r_d.tmr = TMR_BYTE;
                    end
                end
                fcd_pkg::ST_CYC2: begin
                    r_d.st = fcd_pkg::ST_READ;
                    r_d.tmr = TMR_BYTE;
                    if (code1) begin
                        case (wbyte)
                            fcd_pkg::CMD_IDENT: r_d.st = fcd_pkg::ST_IDENT;
                            fcd_pkg::CMD_PROG: r_d.st = fcd_pkg::ST_PROG;
                            fcd_pkg::CMD_ERASE: r_d.st = fcd_pkg::ST_ERS1;
                            fcd_pkg::CMD_BYPASS: begin
                                r_d.st = fcd_pkg::ST_BYP;
                                r_d.bypass = 1'b1;
                            end
                            default: r_d.st = fcd_pkg::ST_READ;
                        endcase
                    end
                end
                fcd_pkg::ST_PROG, fcd_pkg::ST_BYP_PROG: begin
                    r_d.st = r_q.bypass ? fcd_pkg::ST_BYP : fcd_pkg::ST_READ;
                    r_d.cmd.addr = bus_addr;
                    r_d.cmd.data = bus_wdata;
                    r_d.cmd.op = fcd_pkg::OP_PROG;
                    if (!sector_protected) begin
                        if ((bus_wdata & ~array_rdata) != '0) begin
                            r_d.err = 1'b1;
                            r_d.st = fcd_pkg::ST_FAIL;
                        end else begin
                            r_d.cmd.start = 1'b1;
                            r_d.cmd.bank = r_q.bank;
                            r_d.st = fcd_pkg::ST_BUSY;
                        end
                    end
                end
                fcd_pkg::ST_ERS1: begin
                    r_d.st = fcd_pkg::ST_READ;
                    if (wbyte == fcd_pkg::CMD_CODE1 && code1) begin
                        r_d.st = fcd_pkg::ST_ERS2;
                        r_d.tmr = TMR_BYTE;
                    end
                end
                fcd_pkg::ST_ERS2: begin
                    r_d.st = fcd_pkg::ST_READ;
                    if (wbyte == fcd_pkg::CMD_CODE2 && code2) begin
                        r_d.st = fcd_pkg::ST_ERS3;
                        r_d.tmr = TMR_BYTE;
                    end
                end
                fcd_pkg::ST_ERS3: begin
                    r_d.st = fcd_pkg::ST_READ;
                    r_d.cmd.bank = r_q.bank;
                    r_d.cmd.addr = bus_addr;
                    r_d.cmd.sectors = '0;
                    if (wbyte == fcd_pkg::CMD_BULK && code1) begin
                        r_d.cmd.op = fcd_pkg::OP_BULK;
                        if (all_protected) begin
                            r_d.st = fcd_pkg::ST_HOLD;
                            r_d.tmr = TMR_HOLD;
                        end else begin
                            r_d.cmd.start = 1'b1;
                            r_d.st = fcd_pkg::ST_BUSY;
                        end
                    end else if (wbyte == fcd_pkg::CMD_SECT) begin
                        r_d.cmd.op = fcd_pkg::OP_SECT;
                        r_d.cmd.sectors = sector_protected ? 8'h00 : sel_mask;
                        r_d.st = fcd_pkg::ST_ERS_WIN;
                        r_d.tmr = tmr_win;
                    end
                end
                fcd_pkg::ST_ERS_WIN: begin
                    if (wbyte == fcd_pkg::CMD_SECT) begin
                        if (!sector_protected) begin
                            r_d.cmd.sectors = r_q.cmd.sectors | sel_mask;
                        end
                        r_d.tmr = tmr_win;
                    end else begin
                        r_d.st = fcd_pkg::ST_READ;
                        r_d.cmd.sectors = '0;
                    end
                end
                fcd_pkg::ST_IDENT, fcd_pkg::ST_FAIL: begin
                    if (wbyte == fcd_pkg::CMD_RESET && even) begin
                        r_d.st = fcd_pkg::ST_READ;
                        r_d.err = 1'b0;
                    end
                end
                fcd_pkg::ST_BYP: begin
                    if (wbyte == fcd_pkg::CMD_PROG) begin
                        r_d.st = fcd_pkg::ST_BYP_PROG;
                        r_d.tmr = TMR_BYTE;
                    end else if (wbyte == fcd_pkg::CMD_IDENT) begin
                        r_d.st = fcd_pkg::ST_BYP_EXIT;
                        r_d.tmr = TMR_BYTE;
                    end
                end
                fcd_pkg::ST_BYP_EXIT: begin
                    r_d.st = fcd_pkg::ST_BYP;
                    if (wbyte == fcd_pkg::CMD_BYP_EXIT) begin
                        r_d.st = fcd_pkg::ST_READ;
                        r_d.bypass = 1'b0;
                    end
                end
                default: begin
                    // Busy and hold states accept no instruction.
                    r_d.st = cur;
                end
            endcase
        end

        if (alg_fail) begin
            r_d.err = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q.st <= fcd_pkg::ST_READ;
            r_q.bank <= 1'b0;
            r_q.bypass <= 1'b0;
            r_q.err <= 1'b0;
            r_q.tog <= 1'b0;
            r_q.tmr <= fcd_pkg::TMR_RESET;
            r_q.cmd <= '0;
            r_q.rdata <= fcd_pkg::RDATA_RESET;
        end else begin
            r_q <= r_d;
        end
    end

endmodule : fcd_top

// ### tb/fcd_checker.sv
`timescale 1ns/10ps
// Watches the decoder ports for slips in bus answers and algorithm launches.
module fcd_checker #(
    parameter int unsigned ERASE_WIN_CYCLES = 40
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire logic [7:0] primary_sector_selects,
    input wire logic [3:0] secondary_sector_selects,
    input wire logic [15:0] array_rdata,
    input wire logic sector_protected,
    input wire logic all_protected,
    input wire logic alg_busy,
    input wire logic alg_fail,
    input wire fcd_pkg::fcd_alg_cmd_t alg_cmd
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // A status read of the primary bank while its operation has been running.
    sequence busy_rd;
        $past(bus_rd) && $past(alg_busy) && $past(alg_busy, 2)
            && ($past(primary_sector_selects) != 8'h00) && !alg_cmd.bank;
    endsequence
    reset_quiet_a: assert property ($rose(reset_n) |-> bus_rdata == 16'h0000)
        else $error("read answer not quiet after reset");
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
        else $error("read answer without a read strobe");
    start_pulse_a: assert property (alg_cmd.start |=> !alg_cmd.start)
        else $error("launch pulse longer than one cycle");
    prog_cause_a: assert property (alg_cmd.start && alg_cmd.op == fcd_pkg::OP_PROG
        |-> $past(bus_wr) && alg_cmd.data == $past(bus_wdata) && alg_cmd.addr == $past(bus_addr))
        else $error("program launch not tied to its data write");
    busy_nostart_a: assert property (alg_busy |-> !alg_cmd.start)
        else $error("launch while the algorithm is busy");
    status_mirror_a: assert property (busy_rd |-> bus_rdata[14:13] == bus_rdata[6:5]
        && bus_rdata[11] == bus_rdata[3]) else $error("status bytes differ");
    prog_poll_a: assert property (busy_rd ##0 alg_cmd.op == fcd_pkg::OP_PROG
        |-> bus_rdata[7] != alg_cmd.data[7] && bus_rdata[15] != alg_cmd.data[15])
        else $error("program poll bit not complemented");
    erase_poll_a: assert property (busy_rd ##0 alg_cmd.op != fcd_pkg::OP_PROG
        |-> !bus_rdata[7] && !bus_rdata[15]) else $error("erase poll bit not low");
    erase_flag_a: assert property (busy_rd ##0 alg_cmd.op != fcd_pkg::OP_PROG
        |-> bus_rdata[3] && bus_rdata[11]) else $error("erase window flag low while erasing");
    cover property (alg_cmd.start && alg_cmd.op == fcd_pkg::OP_PROG);
    cover property (alg_cmd.start && alg_cmd.op == fcd_pkg::OP_SECT);
    cover property ($past(bus_rd) && bus_rdata[5]);
endmodule : fcd_checker

bind fcd_top fcd_checker #(.ERASE_WIN_CYCLES(ERASE_WIN_CYCLES)) fcd_checker_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .primary_sector_selects(primary_sector_selects),
    .secondary_sector_selects(secondary_sector_selects), .array_rdata(array_rdata),
    .sector_protected(sector_protected), .all_protected(all_protected),
    .alg_busy(alg_busy), .alg_fail(alg_fail), .alg_cmd(alg_cmd)
);

// ### tb/fcd_alg_model.sv
`timescale 1ns/10ps
// Stand-in for the program and erase algorithm and the stored word at address zero.
module fcd_alg_model #(
    parameter int unsigned BUSY_CYC = 30
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] bus_addr,
    input wire fcd_pkg::fcd_alg_cmd_t alg_cmd,
    input wire logic fail_en,
    output logic [15:0] array_rdata,
    output logic alg_busy,
    output logic alg_fail
);
    logic [15:0] word_q; // Word held at address zero.
    logic [7:0] cnt_q; // Cycles left in the running operation.
    // Other addresses read a pattern made from the address itself.
    assign array_rdata = (bus_addr == 16'h0000) ? word_q : ~bus_addr;
    assign alg_busy = (cnt_q != 8'h00);
    // Runs each launch for a fixed time; a failure is reported as it ends.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= 16'hFFFF;
            cnt_q <= 8'h00;
            alg_fail <= 1'b0;
        end else begin
            alg_fail <= fail_en && (cnt_q == 8'h01);
            if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
            if (alg_cmd.start) begin
                cnt_q <= 8'(BUSY_CYC);
                // Programming only clears bits; erase sets the word back to ones.
                word_q <= (alg_cmd.op == fcd_pkg::OP_PROG) ? (word_q & alg_cmd.data) : 16'hFFFF;
            end
        end
    end
endmodule : fcd_alg_model

// ### tb/fcd_top_tb.sv
`timescale 1ns/10ps
// Drives host bus cycles into the decoder and checks every answer.
module fcd_top_tb;
    localparam int unsigned EW = 40; // Short erase window keeps the run brief.
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] primary_sector_selects = 8'h01;
    logic [3:0] secondary_sector_selects = 4'h0;
    logic sector_protected = 1'b0;
    logic all_protected = 1'b0;
    logic fail_en = 1'b0;
    logic [15:0] bus_rdata, array_rdata, rd;
    logic alg_busy, alg_fail;
    fcd_pkg::fcd_alg_cmd_t alg_cmd;
    int error_cnt = 0;
    int tests_run = 0;
    int starts = 0; // Launches seen so far.
    int n;
    fcd_top #(.ERASE_WIN_CYCLES(EW)) fcd_top_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .primary_sector_selects(primary_sector_selects),
        .secondary_sector_selects(secondary_sector_selects), .array_rdata(array_rdata),
        .sector_protected(sector_protected), .all_protected(all_protected),
        .alg_busy(alg_busy), .alg_fail(alg_fail), .alg_cmd(alg_cmd));
    fcd_alg_model fcd_alg_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_addr(bus_addr), .alg_cmd(alg_cmd), .fail_en(fail_en),
        .array_rdata(array_rdata), .alg_busy(alg_busy), .alg_fail(alg_fail));
    // The clock runs at 40 MHz.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Counts launch pulses.
    always @(posedge ref_clk) begin
        if (alg_cmd.start === 1'b1) begin
            starts++;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One write cycle; the strobe drops at the edge that takes it.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr
    // One read cycle; the answer is taken in the cycle after the strobe.
    task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] m,
        input logic [15:0] exp);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        rd = bus_rdata;
        chk(what, exp & m, rd & m);
    endtask : rdc
    // Coded opening cycles, upper address bits set on purpose, then a command.
    // host opening cycles
    task automatic cmd(input logic [7:0] c);
        wr(16'hFAAA, 16'h00AA);
        wr(16'h3554, 16'h0055);
        wr(16'h5AAA, {8'h00, c});
    endtask : cmd
    task automatic wait_idle();
        n = 0;
        @(posedge ref_clk);
        #1;
        while (alg_busy !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("busy bound", 16'h0001, 16'(n < 400));
        if (n >= 400) begin
            print_verdict();
        end
    endtask : wait_idle
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Cuts a hang short.
    initial begin
        #1500000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        chk("reset answer", 16'h0000, bus_rdata);
        reset_n <= 1'b1;
        rdc("plain read", 16'h0010, 16'hFFFF, 16'hFFEF);
        cmd(8'h90);
        rdc("ident", 16'h7002, 16'hFFFF, {8'h00, fcd_pkg::IDENT_CODE});
        sector_protected <= 1'b1;
        rdc("prot yes", 16'h0004, 16'hFFFF, 16'h0001);
        sector_protected <= 1'b0;
        rdc("prot no", 16'h0004, 16'hFFFF, 16'h0000);
        wr(16'h0000, 16'h00F0);
        rdc("after reset cmd", 16'h0010, 16'hFFFF, 16'hFFEF);
        primary_sector_selects <= 8'h00;
        secondary_sector_selects <= 4'h1;
        cmd(8'h90);
        rdc("sec no ident", 16'h0002, 16'hFFFF, 16'hFFFD);
        wr(16'h0000, 16'h00F0);
        primary_sector_selects <= 8'h01;
        secondary_sector_selects <= 4'h0;
        cmd(8'h77);
        wr(16'h0AAA, 16'h00A0);
        wr(16'h0000, 16'h1234);
        wr(16'h0AAA, 16'h00AA);
        repeat (3300) @(posedge ref_clk);
        wr(16'h0554, 16'h0055);
        wr(16'h0AAA, 16'h00A0);
        wr(16'h0000, 16'h1234);
        primary_sector_selects <= 8'h00;
        cmd(8'hA0);
        wr(16'h0000, 16'h1234);
        primary_sector_selects <= 8'h01;
        chk("no launch", 16'h0000, 16'(starts));
        cmd(8'hA0);
        wr(16'h0000, 16'h1234);
        rdc("prog poll", 16'h0000, 16'hA0A0, 16'h8080);
        rdc("toggle a", 16'h0000, 16'h4040, rd[6] ? 16'h0000 : 16'h4040);
        rdc("toggle b", 16'h0000, 16'h4040, rd[6] ? 16'h0000 : 16'h4040);
        wait_idle();
        rdc("programmed", 16'h0000, 16'hFFFF, 16'h1234);
        sector_protected <= 1'b1;
        cmd(8'hA0);
        wr(16'h0000, 16'h1234);
        sector_protected <= 1'b0;
        cmd(8'hA0);
        wr(16'h0000, 16'hFFFF);
        chk("launches", 16'h0001, 16'(starts));
        rdc("zero to one", 16'h0000, 16'h2020, 16'h2020);
        wr(16'h0000, 16'h00F0);
        rdc("error cleared", 16'h0000, 16'hFFFF, 16'h1234);
        fail_en <= 1'b1;
        cmd(8'hA0);
        wr(16'h0000, 16'h1030);
        wait_idle();
        fail_en <= 1'b0;
        rdc("alg failure", 16'h0000, 16'h2020, 16'h2020);
        wr(16'h0000, 16'h00F0);
        cmd(8'h80);
        cmd(8'h30);
        rdc("erase window", 16'h0000, 16'h8888, 16'h0000);
        repeat (EW / 2) @(posedge ref_clk);
        primary_sector_selects <= 8'h02;
        wr(16'h2000, 16'h0030);
        primary_sector_selects <= 8'h01;
        n = 0;
        while (starts < 3 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk("window restart", 16'h0001, 16'(n >= EW - 2 && n < 400));
        if (n >= 400) begin
            print_verdict();
        end
        chk("erase op", 16'(fcd_pkg::OP_SECT), 16'(alg_cmd.op));
        chk("erase mask", 16'h0003, 16'(alg_cmd.sectors));
        rdc("erase busy", 16'h0000, 16'h8888, 16'h0808);
        wait_idle();
        rdc("erased", 16'h0000, 16'hFFFF, 16'hFFFF);
        all_protected <= 1'b1;
        cmd(8'h80);
        cmd(8'h10);
        rdc("guarded erase", 16'h0000, 16'hC0C0, 16'h0000);
        all_protected <= 1'b0;
        repeat (4100) @(posedge ref_clk);
        rdc("guard over", 16'h0000, 16'hFFFF, 16'hFFFF);
        cmd(8'h20);
        wr(16'h0000, 16'h00A0);
        wr(16'h0000, 16'h5555);
        wait_idle();
        wr(16'h0000, 16'h0090);
        wr(16'h0000, 16'h0000);
        wr(16'h0000, 16'h00A0);
        wr(16'h0000, 16'h1111);
        rdc("bypass word", 16'h0000, 16'hFFFF, 16'h5555);
        chk("bypass launches", 16'h0004, 16'(starts));
        print_verdict();
    end
endmodule : fcd_top_tb
